// >>> src/motor_pwm_deadtime_fault_ctrl.v
// update control, dead-time insertion and primary fault override for four
// pwm generators driving eight high/low outputs, with an apb register slave.
// assumes raw generator levels, time-base boundary and special-event pulses,
// duty/period buffer values and fault inputs all synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "motor_pwm_consts.vh"

module motor_pwm_deadtime_fault_ctrl
(
  input wire clk, // 100 mhz instruction-cycle clock
  input wire rst, // asynchronous reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, 1 = write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  input wire [3:0] pwm_raw, // raw generator levels, 1 = active
  input wire tb_boundary, // one-cycle pulse at pwm period start
  input wire special_event, // one-cycle special-event compare match
  output wire special_trigger, // postscaled trigger pulse
  input wire [63:0] duty_buffer, // four 16-bit duty buffer values
  output wire [63:0] duty_compare_value, // active duty compare values
  input wire [14:0] period_buffer, // period buffer value
  output wire [14:0] period_active, // active period value
  input wire [7:0] manual_override_en, // 1 = pin taken from manual value
  input wire [7:0] manual_override_val, // manual level per pin
  input wire fault1_in, // primary fault input, active high
  input wire [3:0] fault2_active, // secondary fault forcing per pair
  input wire [7:0] fault2_level, // secondary fault level per pin
  output wire [3:0] high_side_output, // high-side gate drive
  output wire [3:0] low_side_output, // low-side gate drive
  output wire irq // level interrupt
);

  // control registers live in the low half of the bus word
  reg [15:0] update_ctrl_reg;
  reg [15:0] dt_timing_reg;
  reg [15:0] dt_select_reg;
  reg [15:0] fault1_ctrl_reg;
  reg [`IRQ_WIDTH-1:0] irq_status_reg;
  reg [`IRQ_WIDTH-1:0] irq_mask_reg;
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg irq_reg;
  reg [3:0] post_cnt_reg;
  reg trigger_reg;
  reg [63:0] duty_reg;
  reg [14:0] period_reg;
  reg [7:0] ovr_en_reg;
  reg [7:0] ovr_val_reg;
  reg latch_reg;
  reg cycle_hold_reg;
  reg init_reg;
  reg [31:0] rdata_next;
  reg addr_ok;

  // decode, fault and dead-time helpers
  wire wr_en;
  wire clr_latch;
  wire fault_mode_cycle;
  wire fault_active;
  wire [3:0] fault_pairs;
  wire [8:0] dly_a;
  wire [8:0] dly_b;
  wire [3:0] hs_q;
  wire [3:0] ls_q;

  // a write lands only at the edge that ends the access cycle
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign fault_mode_cycle = fault1_ctrl_reg[`F1_MODE_BIT];
  assign fault_active = latch_reg | cycle_hold_reg;
  assign fault_pairs = fault1_ctrl_reg[`F1_ENABLE_HI:`F1_ENABLE_LO];
  // releasing the latch is a w1c of the fault status bit; refused while
  // the input is still asserted so the pins cannot glitch back on
  assign clr_latch = wr_en && (paddr == `OFF_IRQ_STATUS) && pwdata[`IRQ_FAULT1_BIT] && !fault1_in;

  // delay in clk cycles is count shifted by prescale: 1, 2, 4 or 8 cycle units
  assign dly_a = {3'h0, dt_timing_reg[`DT_A_CNT_HI:`DT_A_CNT_LO]}
    << dt_timing_reg[`DT_A_PS_HI:`DT_A_PS_LO];
  assign dly_b = {3'h0, dt_timing_reg[`DT_B_CNT_HI:`DT_B_CNT_LO]}
    << dt_timing_reg[`DT_B_PS_HI:`DT_B_PS_LO];

  // read mux; unimplemented bits come back zero because writes are masked
  always @*
  begin
    rdata_next = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `OFF_UPDATE_CTRL: rdata_next = {16'h0000, update_ctrl_reg};
      `OFF_DT_TIMING: rdata_next = {16'h0000, dt_timing_reg};
      `OFF_DT_SELECT: rdata_next = {16'h0000, dt_select_reg};
      `OFF_FAULT1_CTRL: rdata_next = {16'h0000, fault1_ctrl_reg};
      `OFF_IRQ_STATUS: rdata_next = {30'h0, irq_status_reg};
      `OFF_IRQ_MASK: rdata_next = {30'h0, irq_mask_reg};
      // the state word shows the registered pin levels and fault holds to software
      `OFF_BLOCK_STATE: rdata_next = {22'h0, latch_reg, cycle_hold_reg, ls_q, hs_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // apb slave: data sampled in the setup cycle, ready in the first access cycle
  // no wait states; the read mux settles well inside a cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & ~penable;
      if (psel & ~penable)
      begin
        prdata_reg <= pwrite ? 32'h00000000 : rdata_next;
        pslverr_reg <= ~addr_ok;
      end
      else
      begin
        prdata_reg <= 32'h00000000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      update_ctrl_reg <= `RST_REG16;
      dt_timing_reg <= `RST_REG16;
      dt_select_reg <= `RST_REG16;
      fault1_ctrl_reg <= `RST_REG16;
      irq_mask_reg <= 2'h0;
    end
    else if (wr_en)
    begin
      // reserved bits are dropped here, so reads need no mask
      // status bits are cleared in their own process
      case (paddr)
        `OFF_UPDATE_CTRL: update_ctrl_reg <= pwdata[15:0] & `UPD_WRITE_MASK;
        `OFF_DT_TIMING: dt_timing_reg <= pwdata[15:0];
        `OFF_DT_SELECT: dt_select_reg <= pwdata[15:0] & `DT_SEL_WRITE_MASK;
        `OFF_FAULT1_CTRL: fault1_ctrl_reg <= pwdata[15:0] & `F1_WRITE_MASK;
        `OFF_IRQ_MASK: irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
        default: irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  // sticky status; a new event in the clearing cycle wins over the clear
  // the fault bit follows a level, so it sets again while the fault stands
  // and a clear only sticks once the line has gone low
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status_reg <= 2'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && (paddr == `OFF_IRQ_STATUS))
        irq_status_reg <= (irq_status_reg & ~pwdata[`IRQ_WIDTH-1:0])
          | {trigger_reg, fault1_in};
      else
        irq_status_reg <= irq_status_reg | {trigger_reg, fault1_in};
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // special event postscaler
  // >= rather than == so lowering the ratio mid-count cannot skip a wrap
  // the trigger leaves one cycle after the event that completes the count
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      post_cnt_reg <= 4'h0;
      trigger_reg <= 1'b0;
    end
    else
    begin
      trigger_reg <= 1'b0;
      if (special_event)
      begin
        if (post_cnt_reg >= update_ctrl_reg[`UPD_POSTSCALE_HI:`UPD_POSTSCALE_LO])
        begin
          post_cnt_reg <= 4'h0;
          trigger_reg <= 1'b1;
        end
        else
          post_cnt_reg <= post_cnt_reg + 4'h1;
      end
    end
  end

  // duty, period and manual override transfers
  // period moves on the boundary only; immediate mode applies to duty alone
  // override transfers obey the sync bit even while updates are blocked
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      duty_reg <= 64'h0000000000000000;
      period_reg <= 15'h0000;
      ovr_en_reg <= 8'h00;
      ovr_val_reg <= 8'h00;
    end
    else
    begin
      if (!update_ctrl_reg[`UPD_BLOCK_BIT])
      begin
        if (update_ctrl_reg[`UPD_IMMEDIATE_BIT] || tb_boundary)
          duty_reg <= duty_buffer;
        if (tb_boundary)
          period_reg <= period_buffer;
      end
      if (!update_ctrl_reg[`UPD_OVERRIDE_SYNC_SEL_BIT] || tb_boundary)
      begin
        ovr_en_reg <= manual_override_en;
        ovr_val_reg <= manual_override_val;
      end
    end
  end

  // primary fault: latched or cycle-by-cycle
  // a fault in the release cycle keeps the latch set
  // switching mode drops the other mode's hold at once
  // init_reg gives the pair logic one forced reload after reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latch_reg <= 1'b0;
      cycle_hold_reg <= 1'b0;
      init_reg <= 1'b1;
    end
    else
    begin
      init_reg <= 1'b0;
      if (fault1_in && !fault_mode_cycle)
        latch_reg <= 1'b1;
      else if (clr_latch || fault_mode_cycle)
        latch_reg <= 1'b0;
      if (fault1_in && fault_mode_cycle)
        cycle_hold_reg <= 1'b1;
      else if (tb_boundary || !fault_mode_cycle)
        cycle_hold_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_pair
      reg raw_q_reg;
      reg dt_h_reg;
      reg dt_l_reg;
      reg [8:0] cnt_reg;
      reg hs_reg;
      reg ls_reg;
      reg hs_next;
      reg ls_next;
      wire [8:0] dly_on;

      // going active uses the rising source select, inactive the falling one
      assign dly_on = pwm_raw[g] ? (dt_select_reg[2*g+1] ? dly_b : dly_a)
                                 : (dt_select_reg[2*g] ? dly_b : dly_a);

      // both sides off during the dead time, then the new side turns on
      // counter runs at clk rate with the prescale folded into the length
      // a raw change inside the dead time restarts it with the new length
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          raw_q_reg <= 1'b0;
          dt_h_reg <= 1'b0;
          dt_l_reg <= 1'b0;
          cnt_reg <= 9'h000;
        end
        else if ((pwm_raw[g] != raw_q_reg) || init_reg)
        begin
          raw_q_reg <= pwm_raw[g];
          cnt_reg <= dly_on;
          dt_h_reg <= (dly_on == 9'h000) & pwm_raw[g];
          dt_l_reg <= (dly_on == 9'h000) & ~pwm_raw[g];
        end
        else if (cnt_reg != 9'h000)
        begin
          cnt_reg <= cnt_reg - 9'h001;
          if (cnt_reg == 9'h001)
          begin
            dt_h_reg <= raw_q_reg;
            dt_l_reg <= ~raw_q_reg;
          end
        end
      end

      // priority: fault 1, then fault 2, then manual override, then dead time
      always @*
      begin
        hs_next = ovr_en_reg[2*g+1] ? ovr_val_reg[2*g+1] : dt_h_reg;
        ls_next = ovr_en_reg[2*g] ? ovr_val_reg[2*g] : dt_l_reg;
        if (fault_active && fault_pairs[g])
        begin
          hs_next = fault1_ctrl_reg[`F1_FORCE_LO+2*g+1];
          ls_next = fault1_ctrl_reg[`F1_FORCE_LO+2*g];
        end
        else if (fault2_active[g])
        begin
          hs_next = fault2_level[2*g+1];
          ls_next = fault2_level[2*g];
        end
      end

      // pins leave from flip-flops so the gate drivers never see decode glitches
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          hs_reg <= 1'b0;
          ls_reg <= 1'b0;
        end
        else
        begin
          hs_reg <= hs_next;
          ls_reg <= ls_next;
        end
      end

      assign hs_q[g] = hs_reg;
      assign ls_q[g] = ls_reg;
    end
  endgenerate

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign special_trigger = trigger_reg;
  assign duty_compare_value = duty_reg;
  assign period_active = period_reg;
  assign high_side_output = hs_q;
  assign low_side_output = ls_q;
  assign irq = irq_reg;

endmodule // motor_pwm_deadtime_fault_ctrl

`default_nettype wire

// >>> inc/motor_pwm_consts.vh
// register offsets, field positions and reset values of the
// pwm update, dead-time and primary fault block
// assumes a 32-bit apb bus with each register on an aligned word
`ifndef MOTOR_PWM_CONSTS_VH
`define MOTOR_PWM_CONSTS_VH

`define OFF_UPDATE_CTRL 12'h000
`define OFF_DT_TIMING 12'h004
`define OFF_DT_SELECT 12'h008
`define OFF_FAULT1_CTRL 12'h00c
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_BLOCK_STATE 12'h018

`define RST_REG16 16'h0000

// update control fields
`define UPD_POSTSCALE_HI 11
`define UPD_POSTSCALE_LO 8
`define UPD_IMMEDIATE_BIT 2
`define UPD_OVERRIDE_SYNC_SEL_BIT 1
`define UPD_BLOCK_BIT 0
`define UPD_WRITE_MASK 16'h0f07

// dead-time timing fields
`define DT_B_PS_HI 15
`define DT_B_PS_LO 14
`define DT_B_CNT_HI 13
`define DT_B_CNT_LO 8
`define DT_A_PS_HI 7
`define DT_A_PS_LO 6
`define DT_A_CNT_HI 5
`define DT_A_CNT_LO 0

`define DT_SEL_WRITE_MASK 16'h00ff

// fault 1 control fields
`define F1_FORCE_LO 8
`define F1_MODE_BIT 7
`define F1_ENABLE_HI 3
`define F1_ENABLE_LO 0
`define F1_WRITE_MASK 16'hff8f

// interrupt status bits
`define IRQ_FAULT1_BIT 0
`define IRQ_TRIGGER_BIT 1
`define IRQ_WIDTH 2

`endif

// >>> test/pwm_ctrl_assertions.sv
// checker: apb answer timing and trigger pulse of the pwm control block
// assumes it is bound into the block top, whose port names it reuses
`timescale 1ns/100ps
`default_nettype none
module pwm_ctrl_checker
(
  input wire clk, // clock
  input wire rst, // async reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire special_event, // event in
  input wire special_trigger // trigger out
);
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (rst);
  a_trig_after_event: assert property (special_trigger |-> $past(special_event))
    else $error("trigger without an event");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_ready_first: assert property (psel && penable && !$past(penable) |-> pready)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_idle_no_data: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside access");
endmodule // pwm_ctrl_checker
bind motor_pwm_deadtime_fault_ctrl pwm_ctrl_checker u_chk (.clk, .rst, .psel, .penable,
  .prdata, .pready, .pslverr, .special_event, .special_trigger);
`default_nettype wire

// >>> test/power_stage_model.sv
// gate driver and fault source model for the pwm control block
// assumes active-high drives; the fault line idles low, as on a pull-down
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
(
  input wire logic clk, // clock
  input wire logic [3:0] hi, // high-side drive
  input wire logic [3:0] lo, // low-side drive
  input wire logic fault_req, // bench asks for a fault
  output logic fault_pin, // fault line into the block
  output int overlap_cnt // cycles with both switches of a pair on
);
  initial fault_pin = 1'b0;
  initial overlap_cnt = 0;
  // the line is registered, as a real comparator output would be
  always @(posedge clk)
  begin
    fault_pin <= fault_req;
    if ((hi & lo) != 4'h0)
      overlap_cnt <= overlap_cnt + 1;
  end
endmodule // power_stage_model
`default_nettype wire

// >>> test/motor_pwm_deadtime_fault_ctrl_tb.sv
// self-checking bench of the pwm update, dead-time and fault block
// assumes the designer's register map and zero-wait-state apb slave
`timescale 1ns/100ps
`default_nettype none
`include "motor_pwm_consts.vh"
module motor_pwm_deadtime_fault_ctrl_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tb_boundary, special_event;
  logic special_trigger, fault1_in, fault_req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pwm_raw, fault2_active, high_side_output, low_side_output;
  logic [63:0] duty_buffer, duty_compare_value;
  logic [14:0] period_buffer, period_active;
  logic [7:0] manual_override_en, manual_override_val, fault2_level;
  int err_total, n_checks, ovl;
  motor_pwm_deadtime_fault_ctrl dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_raw, .tb_boundary, .special_event,
    .special_trigger, .duty_buffer, .duty_compare_value, .period_buffer, .period_active,
    .manual_override_en, .manual_override_val, .fault1_in, .fault2_active, .fault2_level,
    .high_side_output, .low_side_output, .irq);
  power_stage_model stage (.clk, .hi(high_side_output), .lo(low_side_output), .fault_req,
    .fault_pin(fault1_in), .overlap_cnt(ovl));
  task results;
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request held until ready is sampled, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      err_total++;
      results;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic t_regs;
    logic [11:0] ofs [4] = '{`OFF_UPDATE_CTRL, `OFF_DT_TIMING, `OFF_DT_SELECT,
      `OFF_FAULT1_CTRL};
    logic [15:0] msk [4] = '{16'h0f07, 16'hffff, 16'h00ff, 16'hff8f};
    logic [31:0] q;
    logic e;
    foreach (ofs[i])
    begin
      rd_chk(ofs[i], 32'h0);
      wr(ofs[i], 32'hffffffff);
      rd_chk(ofs[i], {16'h0, msk[i]});
      wr(ofs[i], 32'h0);
    end
    apb(1'b0, 12'h01c, 32'h0, q, e);
    chk({e, q}, 33'h100000000);
  endtask
  task automatic t_trig(input logic [3:0] s, input int ev);
    int c;
    wr(`OFF_UPDATE_CTRL, {20'h0, s, 8'h0});
    c = 0;
    repeat (ev)
    begin
      special_event <= 1'b1;
      @(posedge clk);
      special_event <= 1'b0;
      repeat (2)
      begin
        @(posedge clk);
        c += special_trigger;
      end
    end
    chk(c, ev / (s + 1));
    rd_chk(`OFF_IRQ_STATUS, 32'h2);
    wr(`OFF_IRQ_STATUS, 32'h3);
  endtask
  // d = count << prescale; the loop reads pre-edge values, so the new side
  // is seen d+3 edges after the raw change is driven
  task automatic t_dt(input logic [15:0] t, input logic [7:0] s, input int dr, input int df);
    int k;
    wr(`OFF_DT_TIMING, {16'h0, t});
    wr(`OFF_DT_SELECT, {24'h0, s});
    for (int p = 0; p < 2; p++)
    begin
      pwm_raw <= {3'h0, p == 0};
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while ((p == 0 ? high_side_output[0] : low_side_output[0]) !== 1'b1 && k < 300);
      chk(k, (p == 0 ? dr : df) + 3);
      chk(high_side_output[0] & low_side_output[0], 1'b0);
    end
  endtask
  task automatic t_fault(input logic cyc_mode);
    wr(`OFF_IRQ_MASK, {31'h0, !cyc_mode});
    wr(`OFF_FAULT1_CTRL, {16'h0, 8'h0b, cyc_mode, 7'h02});
    fault2_active <= 4'h2;
    fault2_level <= 8'h04;
    fault_req <= 1'b1;
    cyc(4);
    chk({high_side_output, low_side_output}, 8'h2d);
    fault_req <= 1'b0;
    fault2_active <= 4'h0;
    cyc(4);
    chk({high_side_output, low_side_output}, 8'h2d);
    rd_chk(`OFF_BLOCK_STATE, {22'h0, !cyc_mode, cyc_mode, 8'hd2});
    rd_chk(`OFF_IRQ_MASK, {31'h0, !cyc_mode});
    chk(irq, !cyc_mode);
    rd_chk(`OFF_IRQ_STATUS, 32'h1);
    if (cyc_mode)
    begin
      tb_boundary <= 1'b1;
      @(posedge clk);
      tb_boundary <= 1'b0;
    end
    else
      wr(`OFF_IRQ_STATUS, 32'h1);
    cyc(5);
    chk({high_side_output, low_side_output}, 8'h0f);
    wr(`OFF_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
  endtask
  task automatic t_duty;
    duty_buffer <= {4{16'h1357}};
    period_buffer <= 15'h1234;
    cyc(4);
    chk({duty_compare_value, period_active}, 79'h0);
    tb_boundary <= 1'b1;
    @(posedge clk);
    tb_boundary <= 1'b0;
    wr(`OFF_UPDATE_CTRL, 32'h5);
    chk({duty_compare_value, period_active}, {{4{16'h1357}}, 15'h1234});
    duty_buffer <= {4{16'h2468}};
    period_buffer <= 15'h0555;
    tb_boundary <= 1'b1;
    @(posedge clk);
    tb_boundary <= 1'b0;
    cyc(3);
    chk({duty_compare_value, period_active}, {{4{16'h1357}}, 15'h1234});
    wr(`OFF_UPDATE_CTRL, 32'h4);
    cyc(2);
    chk({duty_compare_value, period_active}, {{4{16'h2468}}, 15'h1234});
  endtask
  task automatic t_ovr;
    wr(`OFF_UPDATE_CTRL, 32'h2);
    manual_override_en <= 8'h03;
    manual_override_val <= 8'h02;
    cyc(4);
    chk({high_side_output, low_side_output}, 8'h0f);
    tb_boundary <= 1'b1;
    @(posedge clk);
    tb_boundary <= 1'b0;
    cyc(3);
    chk({high_side_output, low_side_output}, 8'h1e);
    wr(`OFF_UPDATE_CTRL, 32'h0);
    manual_override_en <= 8'h00;
    cyc(4);
    chk({high_side_output, low_side_output}, 8'h0f);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, pwm_raw, tb_boundary} = {1'b1, 52'h0};
    {special_event, duty_buffer, period_buffer, fault_req, fault2_active} = 85'h0;
    {manual_override_en, manual_override_val, fault2_level} = 24'h0;
    err_total = 0;
    n_checks = 0;
    cyc(6);
    rst <= 1'b0;
    cyc(3);
    t_regs;
    t_trig(4'hf, 16);
    t_trig(4'h2, 6);
    t_trig(4'h0, 3);
    t_dt(16'hc243, 8'h02, 16, 6);
    t_dt(16'hc243, 8'h01, 6, 16);
    t_dt(16'h0185, 8'h00, 20, 20);
    t_dt(16'h0185, 8'h03, 1, 1);
    wr(`OFF_DT_TIMING, 32'h0);
    cyc(3);
    t_fault(1'b0);
    t_fault(1'b1);
    t_duty;
    t_ovr;
    chk(ovl, 0);
    results;
  end
endmodule // motor_pwm_deadtime_fault_ctrl_tb
`default_nettype wire
